// file: cgm_clock_ctrl.sv
// clock gate, clock selector, edge clock divider and master delay loop
`timescale 1ns/10ps
// Overview of operation
// - a disabled quadrant gate holds its clock output low and static.
// - gate enable changes only while the clock is low, so no runt pulse.
// - selector switches between two clocks, glitch-free or plain per mode bit.
// - divider makes a slower clock, divide by 2 or by 3.5 per mode bit.
// - divided phase is fixed by the moment the divider reset is released.
// - divider reset clears the counter and forces every divider output low at once.
// - each divider_a pulse shifts divided outputs by one input clock cycle.
// - delay code equals the delay setting for a quarter of the reference period.
// - output code refreshes only while update_n is low, otherwise it holds.
// - freeze stops the loop internal clock cleanly; release restarts it.
// - lock is high only while the output delay code is valid.
// - current delay code is presented on an eight-bit user output.
// - the same code drives a dedicated output to slave delay blocks.
// - slave delay shifts its clock input by the code, a quarter period.
module cgm_clock_ctrl
    import cgm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sel_clk_a,
    input wire logic sel_clk_b,
    input wire logic ref_clk,
    input wire logic slave_clk_in,
    output logic gated_clk,
    output logic sel_clk_out,
    output logic div_clk,
    output logic [7:0] user_delay_code,
    output logic [7:0] delay_code_to_slaves,
    output logic dll_lock,
    output logic slave_clk_out
);
    // divider pattern on the rising-edge half
    function automatic logic div_pos_hi(input logic div35, input logic [2:0] cnt);
        if (div35) begin
            div_pos_hi = (cnt == CGM_DIV35_HI_A) || (cnt == CGM_DIV35_HI_B) ||
                (cnt == CGM_DIV35_HI_D);
        end else begin
            div_pos_hi = (cnt == CGM_DIV35_HI_A);
        end
    endfunction : div_pos_hi

    // divider pattern on the falling-edge half, only used for the half-cycle mode
    function automatic logic div_neg_hi(input logic div35, input logic [2:0] cnt);
        div_neg_hi = div35 && ((cnt == CGM_DIV35_HI_C) || (cnt == CGM_DIV35_HI_D));
    endfunction : div_neg_hi

    logic [CGM_CTRL_W-1:0] ctrl_q;
    logic divider_a_q;
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_hit;

    // write side takes address and data in either order, answers after both
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid;
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // register update and write response; all writable fields live in byte lane 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CGM_CTRL_RESET;
            divider_a_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CGM_RESP_OKAY;
        end else begin
            divider_a_q <= 1'b0;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= CGM_RESP_OKAY;
                if (awaddr_q == CGM_ADDR_CTRL) begin
                    if (wstrb_q[0]) begin
                        ctrl_q <= wdata_q[CGM_CTRL_W-1:0];
                    end
                end else if (awaddr_q == CGM_ADDR_DIVIDER_A) begin
                    divider_a_q <= wstrb_q[0] && wdata_q[CGM_DIVIDER_A_BIT];
                end else if (awaddr_q != CGM_ADDR_STAT && awaddr_q != CGM_ADDR_MEAS) begin
                    s_axi_bresp <= CGM_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [CGM_MEAS_W-1:0] meas_q;
    logic [7:0] out_code_q;
    logic sel_cur_q;
    cgm_sel_state_type sel_state_q;

    // read mux; unmapped addresses read zero with an error response
    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            CGM_ADDR_CTRL: rd_word[CGM_CTRL_W-1:0] = ctrl_q;
            CGM_ADDR_DIVIDER_A: rd_word = '0;
            CGM_ADDR_STAT: begin
                rd_word[CGM_STAT_LOCK] = dll_lock;
                rd_word[CGM_STAT_SEL_CUR] = sel_cur_q;
                rd_word[CGM_STAT_PARKED] = (sel_state_q == CGM_SEL_PARK);
                rd_word[CGM_STAT_CODE_LSB +: 8] = out_code_q;
            end
            CGM_ADDR_MEAS: rd_word[CGM_MEAS_W-1:0] = meas_q;
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= CGM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? CGM_RESP_OKAY : CGM_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // quadrant gate: enable retimed on the falling edge, so it moves only while clk is low
    logic gate_en_neg_q;
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_en_neg_q <= 1'b0;
        end else begin
            gate_en_neg_q <= ctrl_q[CGM_CTRL_GATE_EN];
        end
    end
    assign gated_clk = clk & gate_en_neg_q;

    // pin clocks enter through two-stage synchronisers
    logic a_m_q, a_s_q, b_m_q, b_s_q, ref_m_q, ref_s_q, ref_d_q, slv_m_q, slv_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_m_q <= 1'b0;
            a_s_q <= 1'b0;
            b_m_q <= 1'b0;
            b_s_q <= 1'b0;
            ref_m_q <= 1'b0;
            ref_s_q <= 1'b0;
            ref_d_q <= 1'b0;
            slv_m_q <= 1'b0;
            slv_s_q <= 1'b0;
        end else begin
            a_m_q <= sel_clk_a;
            a_s_q <= a_m_q;
            b_m_q <= sel_clk_b;
            b_s_q <= b_m_q;
            ref_m_q <= ref_clk;
            ref_s_q <= ref_m_q;
            ref_d_q <= ref_s_q;
            slv_m_q <= slave_clk_in;
            slv_s_q <= slv_m_q;
        end
    end

    // selector; plain mode swaps at once, so stopped inputs never block it
    logic old_lvl, new_lvl, sel_out_q;
    assign old_lvl = sel_cur_q ? b_s_q : a_s_q;
    assign new_lvl = ctrl_q[CGM_CTRL_SEL] ? b_s_q : a_s_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_state_q <= CGM_SEL_RUN;
            sel_cur_q <= 1'b0;
            sel_out_q <= 1'b0;
        end else begin
            case (sel_state_q)
                CGM_SEL_RUN: begin
                    if (ctrl_q[CGM_CTRL_SEL] == sel_cur_q) begin
                        sel_out_q <= old_lvl;
                    end else if (!ctrl_q[CGM_CTRL_GLITCHLESS]) begin
                        sel_cur_q <= ctrl_q[CGM_CTRL_SEL];
                        sel_out_q <= new_lvl;
                    end else if (!old_lvl) begin
                        sel_state_q <= CGM_SEL_PARK;
                        sel_out_q <= 1'b0;
                    end else begin
                        sel_out_q <= old_lvl;
                    end
                end
                CGM_SEL_PARK: begin
                    sel_out_q <= 1'b0;
                    if (!new_lvl) begin
                        sel_cur_q <= ctrl_q[CGM_CTRL_SEL];
                        sel_state_q <= CGM_SEL_RUN;
                    end
                end
                default: begin
                    sel_state_q <= CGM_SEL_RUN;
                    sel_out_q <= 1'b0;
                end
            endcase
        end
    end
    assign sel_clk_out = sel_out_q;

    // divider counter; held at zero in reset so release fixes the phase
    logic [2:0] div_cnt_q, div_cnt_d, div_last;
    logic div_pos_q, div_neg_q, div_rst;
    assign div_rst = ctrl_q[CGM_CTRL_DIV_RST];
    assign div_last = ctrl_q[CGM_CTRL_DIV35] ? CGM_DIV35_LAST : CGM_DIV2_LAST;
    always_comb begin
        if (div_rst) begin
            div_cnt_d = '0;
        end else if (divider_a_q) begin
            div_cnt_d = div_cnt_q;
        end else if (div_cnt_q >= div_last) begin
            div_cnt_d = '0;
        end else begin
            div_cnt_d = div_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
            div_pos_q <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            div_pos_q <= !div_rst && div_pos_hi(ctrl_q[CGM_CTRL_DIV35], div_cnt_d);
        end
    end

    // falling-edge half gives the half-cycle step of divide by 3.5
    always_ff @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_neg_q <= 1'b0;
        end else begin
            div_neg_q <= !div_rst && div_neg_hi(ctrl_q[CGM_CTRL_DIV35], div_cnt_q);
        end
    end
    // reset gates the output directly, not waiting for any edge
    assign div_clk = (div_pos_q | div_neg_q) & !div_rst;

    // loop measures the reference period; freeze is registered so it stops cleanly
    logic frz_q, ref_rise;
    logic [CGM_MEAS_W-1:0] run_cnt_q;
    logic [1:0] match_q;
    logic [7:0] code_raw, code_next;
    assign ref_rise = ref_s_q && !ref_d_q;
    assign code_raw = (meas_q[CGM_MEAS_W-1:CGM_QUARTER_SHIFT] > CGM_MEAS_W'(8'hFF)) ?
        8'hFF : meas_q[CGM_QUARTER_SHIFT +: 8];
    assign code_next = ctrl_q[CGM_CTRL_UPDATE_N] ? out_code_q : code_raw;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frz_q <= 1'b0;
            run_cnt_q <= CGM_MEAS_ONE;
            meas_q <= '0;
            match_q <= '0;
        end else begin
            frz_q <= ctrl_q[CGM_CTRL_FREEZE];
            if (!frz_q) begin
                if (ref_rise) begin
                    meas_q <= run_cnt_q;
                    run_cnt_q <= CGM_MEAS_ONE;
                    if (run_cnt_q != meas_q) begin
                        match_q <= '0;
                    end else if (match_q != CGM_LOCK_MATCHES) begin
                        match_q <= match_q + 2'h1;
                    end
                end else if (run_cnt_q != CGM_MEAS_MAX) begin
                    run_cnt_q <= run_cnt_q + CGM_MEAS_ONE;
                end
            end
        end
    end

    // output code and lock; the bus holds a stale code while update_n is high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_code_q <= '0;
            dll_lock <= 1'b0;
        end else begin
            out_code_q <= code_next;
            dll_lock <= (match_q == CGM_LOCK_MATCHES) && (code_next == code_raw) &&
                (code_raw != '0);
        end
    end
    assign user_delay_code = out_code_q;
    assign delay_code_to_slaves = out_code_q;

    // slave delay: one pending edge at a time, so code must stay below half a period
    logic slv_last_q, slv_pend_q;
    logic [7:0] slv_cnt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slv_last_q <= 1'b0;
            slv_pend_q <= 1'b0;
            slv_cnt_q <= '0;
            slave_clk_out <= 1'b0;
        end else if (slv_pend_q) begin
            if (slv_cnt_q == '0) begin
                slave_clk_out <= slv_last_q;
                slv_pend_q <= 1'b0;
            end else begin
                slv_cnt_q <= slv_cnt_q - 8'h01;
            end
        end else if (slv_s_q != slv_last_q) begin
            slv_last_q <= slv_s_q;
            slv_pend_q <= 1'b1;
            slv_cnt_q <= delay_code_to_slaves;
        end
    end

    // checks
    sequence park_s;
        (sel_state_q == CGM_SEL_PARK) && !sel_out_q;
    endsequence
    sequence join_s;
        (sel_state_q == CGM_SEL_RUN) && !sel_out_q;
    endsequence

    gate_off_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[CGM_CTRL_GATE_EN] ##1 !ctrl_q[CGM_CTRL_GATE_EN] |-> !gate_en_neg_q)
        else $error("gate enable not dropped");
    sel_plain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (sel_state_q == CGM_SEL_RUN) && !ctrl_q[CGM_CTRL_GLITCHLESS] &&
        (ctrl_q[CGM_CTRL_SEL] != sel_cur_q) |=> sel_cur_q == $past(ctrl_q[CGM_CTRL_SEL]))
        else $error("plain select did not switch");
    sel_park_join_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(sel_state_q == CGM_SEL_PARK) |-> !sel_out_q throughout (park_s ##[1:24] join_s))
        else $error("parked output not low");
    div_reset_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        div_rst |-> !div_clk && div_cnt_d == '0)
        else $error("divider output high in reset");
    div_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(div_rst) && !ctrl_q[CGM_CTRL_DIV35] && !divider_a_q ##1 !divider_a_q [*3] |->
        !div_pos_q ##1 div_pos_q ##1 !div_pos_q)
        else $error("divide by two pattern wrong");
    div_divider_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        divider_a_q && !div_rst |=> div_cnt_q == $past(div_cnt_q))
        else $error("divider_a did not hold the counter");
    code_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[CGM_CTRL_UPDATE_N] |=> $stable(out_code_q))
        else $error("code changed while update blocked");
    code_quarter_a: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl_q[CGM_CTRL_UPDATE_N] && meas_q < CGM_MEAS_MAX |=>
        out_code_q == $past(meas_q[CGM_QUARTER_SHIFT +: 8]))
        else $error("code is not a quarter period");
    lock_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
        dll_lock |-> out_code_q != '0 && $past(match_q) == CGM_LOCK_MATCHES)
        else $error("lock without valid code");
    freeze_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        frz_q |=> $stable(run_cnt_q) && $stable(meas_q))
        else $error("loop ran while frozen");
endmodule : cgm_clock_ctrl

// file: cgm_pkg.sv
// constants and types shared by the clock management block
package cgm_pkg;
    // register byte addresses on the bus
    localparam logic [7:0] CGM_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CGM_ADDR_DIVIDER_A = 8'h04;
    localparam logic [7:0] CGM_ADDR_STAT = 8'h08;
    localparam logic [7:0] CGM_ADDR_MEAS = 8'h0C;
    // control register fields
    localparam int CGM_CTRL_GATE_EN = 0;
    localparam int CGM_CTRL_SEL = 1;
    localparam int CGM_CTRL_GLITCHLESS = 2;
    localparam int CGM_CTRL_DIV35 = 3;
    localparam int CGM_CTRL_DIV_RST = 4;
    localparam int CGM_CTRL_FREEZE = 5;
    localparam int CGM_CTRL_UPDATE_N = 6;
    localparam int CGM_CTRL_W = 7;
    localparam logic [6:0] CGM_CTRL_RESET = 7'h45;
    // divider_a register field
    localparam int CGM_DIVIDER_A_BIT = 0;
    // status register fields
    localparam int CGM_STAT_LOCK = 0;
    localparam int CGM_STAT_SEL_CUR = 1;
    localparam int CGM_STAT_PARKED = 2;
    localparam int CGM_STAT_CODE_LSB = 8;
    // bus responses
    localparam logic [1:0] CGM_RESP_OKAY = 2'b00;
    localparam logic [1:0] CGM_RESP_SLVERR = 2'b10;
    // divider counter wrap points and output-high counts, in input clock cycles
    localparam logic [2:0] CGM_DIV2_LAST = 3'h1;
    localparam logic [2:0] CGM_DIV35_LAST = 3'h6;
    localparam logic [2:0] CGM_DIV35_HI_A = 3'h0;
    localparam logic [2:0] CGM_DIV35_HI_B = 3'h1;
    localparam logic [2:0] CGM_DIV35_HI_C = 3'h3;
    localparam logic [2:0] CGM_DIV35_HI_D = 3'h4;
    // delay loop measurement
    localparam int CGM_MEAS_W = 10;
    localparam logic [9:0] CGM_MEAS_MAX = 10'h3FF;
    localparam logic [9:0] CGM_MEAS_ONE = 10'h001;
    localparam int CGM_QUARTER_SHIFT = 2;
    localparam logic [1:0] CGM_LOCK_MATCHES = 2'h2;
    // selector states
    typedef enum logic [1:0] {
        CGM_SEL_RUN = 2'b01,
        CGM_SEL_PARK = 2'b10
    } cgm_sel_state_type;
endpackage : cgm_pkg

// file: cgm_clock_source.sv
// partner model: clocks that the fabric feeds into the clock block
`timescale 1ns/10ps
module cgm_clock_source (
    input wire logic [15:0] ref_half_ns,
    output logic sel_clk_a,
    output logic sel_clk_b,
    output logic ref_clk,
    output logic slave_clk_in
);
    // reference offset by 3 ns so its edges never meet clk edges
    initial begin
        sel_clk_a = 1'b0;
        sel_clk_b = 1'b0;
        ref_clk = 1'b0;
        slave_clk_in = 1'b0;
        #3;
        forever #(ref_half_ns) ref_clk = ~ref_clk;
    end
    // both selector inputs never stop, glitch-free switching needs them
    always #41 sel_clk_a = ~sel_clk_a;
    always #69 sel_clk_b = ~sel_clk_b;
    // clock to be delayed runs at the reference frequency
    always @(ref_clk) slave_clk_in <= #30 ref_clk;
endmodule : cgm_clock_source

// file: tb_cgm_clock_ctrl.sv
// self-checking bench for the clock management block
`timescale 1ns/10ps
module tb_cgm_clock_ctrl;
    import cgm_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic sel_clk_a, sel_clk_b, ref_clk, slave_clk_in;
    logic gated_clk, sel_clk_out, div_clk, dll_lock, slave_clk_out;
    logic [7:0] user_delay_code, delay_code_to_slaves;
    logic [15:0] ref_half_ns = 16'h00a0;
    logic [6:0] ctl = CGM_CTRL_RESET;
    logic watch = 1'b0;
    int seed = 32'h38fe;
    int bad_count = 0, check_count = 0, cyc = 0, runt = 0;
    int g_rise = 0, d_rise = 0, s_rise = 0, gd, dd, sd;
    realtime g_t = 0.0, s_t = 0.0, si_t = 0.0, so_dt = 0.0;

    cgm_clock_ctrl uut (.*);
    cgm_clock_source partner (.*);

    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // edge counters; a high pulse shorter than expected counts as a runt
    always @(posedge gated_clk) begin
        g_rise++;
        g_t = $realtime;
    end
    always @(negedge gated_clk) begin
        if ($realtime - g_t < 3.5) runt++;
    end
    always @(posedge sel_clk_out) begin
        s_rise++;
        s_t = $realtime;
    end
    always @(negedge sel_clk_out) begin
        if (watch && $realtime - s_t < 30.0) runt++;
    end
    always @(posedge div_clk) d_rise++;
    always @(posedge slave_clk_in) si_t = $realtime;
    always @(posedge slave_clk_out) so_dt = $realtime - si_t;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_data

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_resp

    // a wait that ran out of its bound ends the run
    task automatic time_out();
        chk_data(32'h0000_0000, 32'h0000_0001);
        give_verdict();
    endtask : time_out

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        if (n >= 200) time_out();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        // one edge passes, so a following call never drives bready twice at once
        @(posedge clk);
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        if (n >= 200) time_out();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axi_read

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk_resp(r, CGM_RESP_OKAY);
        chk_data(d & m, e);
    endtask : rd_chk

    task automatic put(input int b, input logic v);
        logic [1:0] r;
        ctl[b] = v;
        axi_write(CGM_ADDR_CTRL, 32'(ctl), r);
        chk_resp(r, CGM_RESP_OKAY);
    endtask : put

    // edges counted 2 ns after clk rise, clear of every output edge
    task automatic window(input int w);
        @(posedge clk);
        #2;
        gd = g_rise;
        dd = d_rise;
        sd = s_rise;
        repeat (w) @(posedge clk);
        #2;
        gd = g_rise - gd;
        dd = d_rise - dd;
        sd = s_rise - sd;
        @(posedge clk);
    endtask : window

    task automatic first_rise(output int t);
        int k;
        k = d_rise;
        t = 0;
        while (d_rise == k && t < 50) begin
            @(posedge clk);
            #2;
            t++;
        end
        @(posedge clk);
    endtask : first_rise

    // divider level on an even cycle of the bench counter
    task automatic samp(output logic v);
        @(posedge clk);
        if (cyc[0]) @(posedge clk);
        #2;
        v = div_clk;
        @(posedge clk);
    endtask : samp

    function automatic logic near(input int got, input int ns, input int per);
        return got * per >= ns - per && got * per <= ns + per;
    endfunction : near

    // quarter of the reference period in clk cycles, saturated
    function automatic logic [7:0] code_of(input int half);
        return (half / 16 > 255) ? 8'hff : 8'(half / 16);
    endfunction : code_of

    task automatic wait_lock();
        int n;
        n = 0;
        while (dll_lock !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000) time_out();
    endtask : wait_lock

    task automatic dll_check(input int half);
        logic [7:0] c;
        c = code_of(half);
        repeat (200) @(posedge clk);
        chk_data(32'(user_delay_code), 32'(c));
        chk_data(32'(delay_code_to_slaves), 32'(c));
        rd_chk(CGM_ADDR_MEAS, 32'h0000_03ff, 32'(half / 4));
        rd_chk(CGM_ADDR_STAT, 32'h0000_ff01, {16'h0000, c, 8'h01});
        chk_data(32'(so_dt >= (c + 1) * 8 && so_dt <= (c + 5) * 8), 32'h0000_0001);
    endtask : dll_check

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic p0, p1;
        int t1, t2, k;
        repeat (12) @(posedge clk);
        chk_data(32'({div_clk, dll_lock, user_delay_code}), 32'h0000_0000);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk(CGM_ADDR_CTRL, 32'hffff_ffff, 32'(CGM_CTRL_RESET));
        axi_read(8'h10, d, r);
        chk_resp(r, CGM_RESP_SLVERR);
        axi_write(8'h10, 32'h0000_0001, r);
        chk_resp(r, CGM_RESP_SLVERR);
        // gate toggled at random moments, off means no edges at all
        for (int i = 0; i < 6; i++) begin
            put(CGM_CTRL_GATE_EN, 1'($random(seed)));
            repeat (4 + ($random(seed) & 7)) @(posedge clk);
            window(16);
            chk_data(32'(gd), ctl[CGM_CTRL_GATE_EN] ? 32'h0000_0010 : 32'h0000_0000);
        end
        put(CGM_CTRL_GATE_EN, 1'b1);
        // divider: phase after release, reset forcing low, rates, slips
        // divider runs out of reset, so hold it first to fix the phase
        put(CGM_CTRL_DIV_RST, 1'b1);
        put(CGM_CTRL_DIV_RST, 1'b0);
        first_rise(t1);
        put(CGM_CTRL_DIV_RST, 1'b1);
        window(10);
        chk_data(32'({dd, div_clk}), 32'h0000_0000);
        put(CGM_CTRL_DIV_RST, 1'b0);
        first_rise(t2);
        chk_data(32'(t1 == t2 && t1 < 50), 32'h0000_0001);
        window(56);
        chk_data(32'(dd), 32'h0000_001c);
        samp(p0);
        k = 1 + ($random(seed) & 3);
        repeat (k) axi_write(CGM_ADDR_DIVIDER_A, 32'h0000_0001, r);
        samp(p1);
        chk_data(32'(p1), 32'(p0 ^ k[0]));
        put(CGM_CTRL_DIV35, 1'b1);
        put(CGM_CTRL_DIV_RST, 1'b1);
        put(CGM_CTRL_DIV_RST, 1'b0);
        window(56);
        chk_data(32'(dd), 32'h0000_0010);
        // selector in plain mode, then random switching in glitch-free mode
        put(CGM_CTRL_GLITCHLESS, 1'b0);
        window(400);
        chk_data(32'(near(sd, 3200, 82)), 32'h0000_0001);
        put(CGM_CTRL_SEL, 1'b1);
        repeat (10) @(posedge clk);
        window(400);
        chk_data(32'(near(sd, 3200, 138)), 32'h0000_0001);
        put(CGM_CTRL_GLITCHLESS, 1'b1);
        watch = 1'b1;
        for (int i = 0; i < 8; i++) begin
            put(CGM_CTRL_SEL, 1'($random(seed)));
            repeat (20 + ($random(seed) & 63)) @(posedge clk);
        end
        repeat (100) @(posedge clk);
        rd_chk(CGM_ADDR_STAT, 32'h0000_0006, 32'(ctl[CGM_CTRL_SEL]) << 1);
        window(400);
        chk_data(32'(near(sd, 3200, ctl[CGM_CTRL_SEL] ? 138 : 82)), 32'h0000_0001);
        chk_data(32'(runt), 32'h0000_0000);
        watch = 1'b0;
        // delay loop: lock, held code, fresh code, freeze and restart
        // update is only dropped here, with no memory cycle open
        put(CGM_CTRL_UPDATE_N, 1'b0);
        wait_lock();
        dll_check(160);
        put(CGM_CTRL_UPDATE_N, 1'b1);
        ref_half_ns <= 16'h00f0;
        repeat (1500) @(posedge clk);
        chk_data(32'({dll_lock, user_delay_code}), 32'(code_of(160)));
        put(CGM_CTRL_UPDATE_N, 1'b0);
        wait_lock();
        dll_check(240);
        put(CGM_CTRL_FREEZE, 1'b1);
        ref_half_ns <= 16'h00a0;
        repeat (1500) @(posedge clk);
        rd_chk(CGM_ADDR_MEAS, 32'h0000_03ff, 32'h0000_003c);
        put(CGM_CTRL_FREEZE, 1'b0);
        repeat (1500) @(posedge clk);
        dll_check(160);
        give_verdict();
    end
endmodule : tb_cgm_clock_ctrl
